// ---- rtl/csdram_defines.svh ----
// offsets, field positions, reset values of the chip-select / dram area block
// included by the block's package user files; definitions only
`ifndef CSDRAM_DEFINES_SVH
`define CSDRAM_DEFINES_SVH
`define CSO_OFF 4'h0
`define DAC_OFF 4'h4
`define STAT_OFF 4'h8
`define CSO_RST 8'h0f
`define DAC_RST 8'h10
`define CSO_RO_MASK 8'h0f
`define DAC_RO_MASK 8'h10
`define CSO_EN_LSB 4
`define DAC_SEL_LSB 5
`define DAC_BE 3
`define DAC_RDM 2
`define DAC_SRF 1
`define DAC_RFE 0
`define NBR_SEL_TIMER 2'h1
`define CMF_BIT 7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- rtl/csdram_pkg.sv ----
// types shared by the chip-select / dram area block
// no assumptions beyond a sv-2012 compiler
package csdram_pkg;
  typedef enum logic [1:0]
  {
    PIN_PORT = 2'b00,
    PIN_CS = 2'b01,
    PIN_RAS = 2'b10
  } pin_func_e;
  typedef enum logic
  {
    SR_NORMAL = 1'b0,
    SR_ACTIVE = 1'b1
  } sr_state_e;
  // write toward a neighbouring dram/refresh register
  typedef struct packed
  {
    logic [1:0] sel;
    logic [7:0] data;
  } nbr_wr_s;
endpackage

// ---- rtl/axil_regport.sv ----
// axi4-lite slave front end: one write and one read at a time
// assumes the user side decodes addresses combinationally
`timescale 1ns/1ps
`default_nettype none
`include "csdram_defines.svh"
module axil_regport #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // axi4-lite
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // user side
  output logic wr_stb,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_be,
  input wire logic wr_ok,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_have_r;
  logic w_have_r;

  // readies are flops: high only while idle, dropped at their own handshake
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !(s_axi_awvalid && s_axi_awready) && !aw_have_r && !s_axi_bvalid && !wr_stb;
      s_axi_wready <= !(s_axi_wvalid && s_axi_wready) && !w_have_r && !s_axi_bvalid && !wr_stb;
      s_axi_arready <= !(s_axi_arvalid && s_axi_arready) && !s_axi_rvalid;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      wr_stb <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_be <= '0;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_be <= s_axi_wstrb;
      end
      if (aw_have_r && w_have_r)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        wr_stb <= 1'b1;
      end
      if (wr_stb)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_data : 32'h0000_0000;
      s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // axil_regport
`default_nettype wire

// ---- rtl/area_decode.sv ----
// decodes the dram area select code into dram areas and row-strobe pins
// purely combinational; index 0 is area 2 / select pin 2
`timescale 1ns/1ps
`default_nettype none
module area_decode (
  // code in
  input wire logic [2:0] code,
  // decoded
  output logic [3:0] area_dram,
  output logic [3:0] ras_pin
);
  always_comb
  begin
    case (code)
      3'h0:
      begin
        area_dram = 4'h0;
        ras_pin = 4'h0;
      end
      3'h1:
      begin
        area_dram = 4'h1;
        ras_pin = 4'h1;
      end
      3'h2:
      begin
        area_dram = 4'h3;
        ras_pin = 4'h3;
      end
      3'h3:
      begin
        area_dram = 4'h3;
        ras_pin = 4'h1;
      end
      3'h4:
      begin
        area_dram = 4'h7;
        ras_pin = 4'h7;
      end
      3'h5:
      begin
        area_dram = 4'hf;
        ras_pin = 4'hf;
      end
      3'h6:
      begin
        area_dram = 4'hf;
        ras_pin = 4'h5;
      end
      default:
      begin
        area_dram = 4'hf;
        ras_pin = 4'h1;
      end
    endcase
  end
endmodule // area_decode
`default_nettype wire

// ---- rtl/csdram_ctrl.sv ----
// chip-select output and dram area configuration with axi4-lite access
// assumes mode and standby inputs synchronous to clk
// Notes on behaviour
// - select output control is 8 bits, reset and hw standby load, sw standby keeps
// - upper four bits enable select outputs 7 to 4, reset zero
// - an enabled select output claims its pin over any other function
// - writes to select output control ignored in single-chip mode
// - low four bits of select output control read one, ignore writes
// - dram area control is 8 bits, reset and hw standby load, sw standby keeps
// - area code, expanded mode only: 000 none, 001, 010, 011 mappings
// - codes 100 and 101 map areas 2-4 / 2-5 onto their own row-strobe pins, 110 and 111 share pins
// - select pins not used as row strobe stay general port pins
// - any dram area in expanded mode blocks neighbour writes, flag clear excepted
// - bit 4 of dram area control reads one, ignores writes
// - burst enable selects fast page mode, else full access
// - row-hold bit keeps row strobe low between interrupted burst accesses
// - self-refresh bit plus dram area makes sw standby self-refresh the dram
// - leaving sw standby restores normal access
// - refresh pin enable drives refresh signal, else pin is a port
// - with area code 000 dram control b settings have no effect
`timescale 1ns/1ps
`default_nettype none
`include "csdram_defines.svh"
module csdram_ctrl #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // axi4-lite register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // operating mode
  input wire logic single_chip,
  input wire logic hw_standby,
  input wire logic sw_standby,
  // dram access state from the bus engine
  input wire logic dram_acc,
  input wire logic refresh_req,
  // neighbour register writes
  input wire logic nbr_wr_valid,
  input wire csdram_pkg::nbr_wr_s nbr_wr_in,
  output logic nbr_wr_go,
  output csdram_pkg::nbr_wr_s nbr_wr_out,
  output logic cmf_clear,
  // pin functions and dram behaviour
  output csdram_pkg::pin_func_e [5:0] pin_func,
  output logic [3:0] area_dram,
  output logic burst_mode,
  output logic ras_hold,
  output logic self_refresh,
  output logic refresh_pin_o,
  output logic refresh_pin_oe,
  output logic dram_control_b_effective
);
  // elaboration check on the address width
  if (ADDR_W < 4)
  begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  logic wr_stb;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_be;
  logic [7:0] cso_r;
  logic [7:0] dac_r;
  logic [31:0] rd_data;
  logic wr_ok;
  logic rd_ok;
  logic [2:0] eff_code;
  logic dram_any;
  logic [3:0] dram_dec;
  logic [3:0] ras_dec;
  logic nbr_block;
  logic dram_acc_prev_r;
  logic sw_prev_r;
  csdram_pkg::sr_state_e sr_state_r;

  function automatic logic [ADDR_W-1:0] off(input logic [3:0] o);
    off = ADDR_W'(o);
  endfunction

  axil_regport #(.ADDR_W(ADDR_W)) u_bus (
    .clk(clk),
    .srst(srst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_be(wr_be),
    .wr_ok(wr_ok),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // area code counts only in expanded mode
  assign eff_code = single_chip ? 3'h0 : dac_r[`DAC_SEL_LSB +: 3];
  assign dram_any = |eff_code;

  area_decode u_dec (
    .code(eff_code),
    .area_dram(dram_dec),
    .ras_pin(ras_dec)
  );

  assign wr_ok = (wr_addr == off(`CSO_OFF)) || (wr_addr == off(`DAC_OFF)) || (wr_addr == off(`STAT_OFF));
  assign rd_ok = (s_axi_araddr == off(`CSO_OFF)) || (s_axi_araddr == off(`DAC_OFF))
    || (s_axi_araddr == off(`STAT_OFF));

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (s_axi_araddr == off(`CSO_OFF))
      rd_data[7:0] = cso_r;
    else if (s_axi_araddr == off(`DAC_OFF))
      rd_data[7:0] = dac_r;
    else if (s_axi_araddr == off(`STAT_OFF))
      rd_data[7:0] = {self_refresh, ras_hold, burst_mode, dram_control_b_effective, area_dram};
  end

  // select output control register
  always_ff @(posedge clk)
  begin
    if (srst || hw_standby)
      cso_r <= `CSO_RST;
    else if (wr_stb && wr_be[0] && wr_addr == off(`CSO_OFF) && !single_chip)
      cso_r <= (wr_data[7:0] & ~`CSO_RO_MASK) | `CSO_RO_MASK;
  end

  // dram area control register
  always_ff @(posedge clk)
  begin
    if (srst || hw_standby)
      dac_r <= `DAC_RST;
    else if (wr_stb && wr_be[0] && wr_addr == off(`DAC_OFF))
      dac_r <= (wr_data[7:0] & ~`DAC_RO_MASK) | `DAC_RO_MASK;
  end

  // pin ownership: enabled select output first, then row strobe, else port
  always_ff @(posedge clk)
  begin
    if (srst)
      for (int k = 0; k < 6; k++)
        pin_func[k] <= csdram_pkg::PIN_PORT;
    else
    begin
      for (int k = 0; k < 6; k++)
      begin
        if (k >= 2 && cso_r[`CSO_EN_LSB + k - 2])
          pin_func[k] <= csdram_pkg::PIN_CS;
        else if (k < 4 && ras_dec[k])
          pin_func[k] <= csdram_pkg::PIN_RAS;
        else
          pin_func[k] <= csdram_pkg::PIN_PORT;
      end
    end
  end

  // dram access behaviour
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      area_dram <= 4'h0;
      burst_mode <= 1'b0;
      dram_control_b_effective <= 1'b0;
    end
    else
    begin
      area_dram <= dram_dec;
      burst_mode <= dram_any && dac_r[`DAC_BE];
      dram_control_b_effective <= dram_any;
    end
  end

  // row strobe kept low across a gap in burst accesses
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dram_acc_prev_r <= 1'b0;
      ras_hold <= 1'b0;
    end
    else
    begin
      dram_acc_prev_r <= dram_acc;
      if (!(dram_any && dac_r[`DAC_BE] && dac_r[`DAC_RDM]) || dram_acc)
        ras_hold <= 1'b0;
      else if (dram_acc_prev_r)
        ras_hold <= 1'b1;
    end
  end

  // self-refresh across software standby
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sw_prev_r <= 1'b0;
      sr_state_r <= csdram_pkg::SR_NORMAL;
      self_refresh <= 1'b0;
    end
    else
    begin
      sw_prev_r <= sw_standby;
      case (sr_state_r)
        csdram_pkg::SR_NORMAL:
        begin
          if (sw_standby && !sw_prev_r && dac_r[`DAC_SRF] && dram_any)
          begin
            sr_state_r <= csdram_pkg::SR_ACTIVE;
            self_refresh <= 1'b1;
          end
        end
        csdram_pkg::SR_ACTIVE:
        begin
          if (!sw_standby)
          begin
            sr_state_r <= csdram_pkg::SR_NORMAL;
            self_refresh <= 1'b0;
          end
        end
        default:
        begin
          sr_state_r <= csdram_pkg::SR_NORMAL;
          self_refresh <= 1'b0;
        end
      endcase
    end
  end

  // refresh pin
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      refresh_pin_oe <= 1'b0;
      refresh_pin_o <= 1'b0;
    end
    else
    begin
      refresh_pin_oe <= dac_r[`DAC_RFE];
      refresh_pin_o <= dac_r[`DAC_RFE] && refresh_req;
    end
  end

  // neighbour write gate
  assign nbr_block = dram_any;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      nbr_wr_go <= 1'b0;
      cmf_clear <= 1'b0;
      nbr_wr_out <= '0;
    end
    else
    begin
      nbr_wr_go <= nbr_wr_valid && !nbr_block;
      cmf_clear <= nbr_wr_valid && nbr_block && nbr_wr_in.sel == `NBR_SEL_TIMER
        && !nbr_wr_in.data[`CMF_BIT];
      if (nbr_wr_valid)
        nbr_wr_out <= nbr_wr_in;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_cso_low_ones;
    cso_r[3:0] == 4'hf;
  endproperty
  a_cso_low_ones: assert property (p_cso_low_ones) else $error("low select bits not one");

  property p_dac_bit4;
    dac_r[4] == 1'b1;
  endproperty
  a_dac_bit4: assert property (p_dac_bit4) else $error("area control bit 4 not one");

  property p_hw_standby_init;
    hw_standby |=> cso_r == 8'h0f && dac_r == 8'h10;
  endproperty
  a_hw_standby_init: assert property (p_hw_standby_init) else $error("standby init failed");

  property p_single_chip_lock;
    single_chip && !hw_standby |=> $stable(cso_r);
  endproperty
  a_single_chip_lock: assert property (p_single_chip_lock) else $error("select reg changed in single-chip");

  property p_cs_override;
    cso_r[7] |=> pin_func[5] == csdram_pkg::PIN_CS;
  endproperty
  a_cs_override: assert property (p_cs_override) else $error("select output not claiming pin");

  property p_ras_map;
    !single_chip && dac_r[7:5] == 3'h6 && cso_r[7:4] == 4'h0 |=>
      pin_func[2] == csdram_pkg::PIN_RAS && pin_func[3] == csdram_pkg::PIN_PORT && area_dram == 4'hf;
  endproperty
  a_ras_map: assert property (p_ras_map) else $error("shared row strobe map wrong");

  property p_nbr_block;
    nbr_wr_valid && !single_chip && dac_r[7:5] != 3'h0 |=> !nbr_wr_go;
  endproperty
  a_nbr_block: assert property (p_nbr_block) else $error("neighbour write passed");

  property p_cmf_clear;
    nbr_wr_valid && !single_chip && dac_r[7:5] != 3'h0 && nbr_wr_in.sel == 2'h1 && !nbr_wr_in.data[7]
      |=> cmf_clear;
  endproperty
  a_cmf_clear: assert property (p_cmf_clear) else $error("flag clear lost");

  property p_sr_enter;
    $rose(sw_standby) && dac_r[1] && dram_any |=> self_refresh ##1 (self_refresh || !sw_standby);
  endproperty
  a_sr_enter: assert property (p_sr_enter) else $error("self-refresh not entered");

  property p_sr_exit;
    $fell(sw_standby) |=> !self_refresh;
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("self-refresh kept after standby");

  property p_refresh_pin_off;
    !dac_r[0] |=> !refresh_pin_oe && !refresh_pin_o;
  endproperty
  a_refresh_pin_off: assert property (p_refresh_pin_off) else $error("refresh pin driven while off");

  property p_code_zero;
    eff_code == 3'h0 |=> !dram_control_b_effective && !burst_mode && area_dram == 4'h0;
  endproperty
  a_code_zero: assert property (p_code_zero) else $error("dram settings active with no area");
endmodule // csdram_ctrl
`default_nettype wire

// ---- bench/dram_side_model.sv ----
// dram-side stand-in: access bursts and the refresh level seen by the block
// assumes go is a one-cycle request, synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module dram_side_model #(
  parameter int ACC_LEN = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // requests from the bench
  input wire logic go,
  input wire logic ref_lvl,
  // toward the block
  output logic dram_acc,
  output logic refresh_req
);
  int cnt_r;
  // one access of ACC_LEN cycles, then a gap
  always_ff @(posedge clk)
  begin
    if (srst)
      cnt_r <= 0;
    else if (go)
      cnt_r <= ACC_LEN;
    else if (cnt_r > 0)
      cnt_r <= cnt_r - 1;
  end
  assign dram_acc = (cnt_r > 0);
  always_ff @(posedge clk)
  begin
    if (srst)
      refresh_req <= 1'b0;
    else
      refresh_req <= ref_lvl;
  end
endmodule // dram_side_model
`default_nettype wire

// ---- bench/chip_select_dram_area_control_tb.sv ----
// self-checking bench for the chip-select / dram area block
// drives axi4-lite and mode inputs; dram side from dram_side_model
`timescale 1ns/1ps
`default_nettype none
`include "csdram_defines.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module chip_select_dram_area_control_tb;
  localparam logic [63:0] TBL = 64'hf1f5ff7731331100;
  logic clk = 1'b0, srst = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf, area_dram;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h0001023a;
  logic awready, wready, bvalid, arready, rvalid, nbr_wr_go, cmf_clear, burst_mode, ras_hold;
  logic self_refresh, refresh_pin_o, refresh_pin_oe, dram_control_b_effective, dram_acc, refresh_req;
  logic [1:0] bresp, rresp, eb;
  logic single_chip = 1'b0, hw_standby = 1'b0, sw_standby = 1'b0, nbr_wr_valid = 1'b0;
  logic burst_go = 1'b0, ref_lvl = 1'b0;
  logic [7:0] v;
  logic [33:0] er;
  csdram_pkg::nbr_wr_s nbr_wr_in = 10'h0, nbr_wr_out;
  csdram_pkg::pin_func_e [5:0] pin_func;
  int failures = 0, samples_checked = 0;
  logic [1:0] wq[$];
  logic [33:0] rq[$];

  csdram_ctrl #(.ADDR_W(4)) u_csdram_ctrl (.clk(clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .single_chip(single_chip), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .dram_acc(dram_acc), .refresh_req(refresh_req), .nbr_wr_valid(nbr_wr_valid), .nbr_wr_in(nbr_wr_in),
    .nbr_wr_go(nbr_wr_go), .nbr_wr_out(nbr_wr_out), .cmf_clear(cmf_clear), .pin_func(pin_func),
    .area_dram(area_dram), .burst_mode(burst_mode), .ras_hold(ras_hold), .self_refresh(self_refresh),
    .refresh_pin_o(refresh_pin_o), .refresh_pin_oe(refresh_pin_oe), .dram_control_b_effective(dram_control_b_effective));
  dram_side_model #(.ACC_LEN(4)) u_dram_side_model (.clk(clk), .srst(srst), .go(burst_go),
    .ref_lvl(ref_lvl), .dram_acc(dram_acc), .refresh_req(refresh_req));

  always #20 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected pin functions: row strobes first, enabled selects override
  function automatic logic [11:0] pf(input logic [3:0] ras, input logic [3:0] en);
    logic [11:0] p;
    p = 12'h0;
    for (int k = 0; k < 6; k++)
    begin
      if (k < 4 && ras[k]) p[2*k +: 2] = csdram_pkg::PIN_RAS;
      if (k >= 2 && en[k-2]) p[2*k +: 2] = csdram_pkg::PIN_CS;
    end
    return p;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    logic dn;
    n = 0;
    dn = 1'b0;
    wq.push_back(r);
    void'(rnd());
    @(posedge clk);
    awaddr <= a;
    wdata <= {seed[31:8], d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!dn && n < 100)
    begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin bready <= 1'b0; dn = 1'b1; end
    end
    if (!dn) failures++;
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    logic dn;
    n = 0;
    dn = 1'b0;
    rq.push_back({r, e});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dn && n < 100)
    begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin rready <= 1'b0; dn = 1'b1; end
    end
    if (!dn) failures++;
  endtask

  task automatic nbr(input logic [1:0] s, input logic d7, input logic eg, input logic ec);
    logic [9:0] p;
    void'(rnd());
    p = {s, d7, seed[6:0]};
    @(posedge clk);
    nbr_wr_valid <= 1'b1;
    nbr_wr_in <= p;
    @(posedge clk);
    nbr_wr_valid <= 1'b0;
    @(negedge clk);
    `CHK("nbr_go", eg, nbr_wr_go)
    `CHK("cmf_clear", ec, cmf_clear)
    `CHK("nbr_out", p, nbr_wr_out)
  endtask

  task automatic print_verdict();
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // response watcher: oldest expectation against each answer
  always @(posedge clk)
  begin
    if (bvalid && bready)
    begin
      eb = (wq.size() > 0) ? wq.pop_front() : 2'hx;
      `CHK("bresp", eb, bresp)
    end
    if (rvalid && rready)
    begin
      er = (rq.size() > 0) ? rq.pop_front() : 34'hx;
      `CHK("rresp", er[33:32], rresp)
      `CHK("rdata", er[31:0], rdata)
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial
  begin
    cyc(8);
    srst <= 1'b0;
    @(negedge clk);
    `CHK("pin_func", 12'h000, pin_func)
    axi_rd(`CSO_OFF, 32'h0000000f, `RESP_OKAY);
    axi_rd(`DAC_OFF, 32'h00000010, `RESP_OKAY);
    axi_rd(4'hc, 32'h0, `RESP_SLVERR);
    for (int i = 0; i < 6; i++)
    begin
      v = 8'(rnd());
      axi_wr(`CSO_OFF, v, `RESP_OKAY);
      axi_rd(`CSO_OFF, {24'h0, v | `CSO_RO_MASK}, `RESP_OKAY);
      `CHK("pin_func", pf(4'h0, v[7:4]), pin_func)
    end
    single_chip <= 1'b1;
    axi_wr(`CSO_OFF, ~v, `RESP_OKAY);
    axi_rd(`CSO_OFF, {24'h0, v | `CSO_RO_MASK}, `RESP_OKAY);
    single_chip <= 1'b0;
    for (int c = 0; c < 8; c++)
    begin
      axi_wr(`CSO_OFF, {2'h0, {2{c[0]}}, 4'h0}, `RESP_OKAY);
      axi_wr(`DAC_OFF, 8'h00, `RESP_OKAY);
      axi_wr(`DAC_OFF, {c[2:0], 5'h00}, `RESP_OKAY);
      axi_rd(`DAC_OFF, {24'h0, c[2:0], 5'h10}, `RESP_OKAY);
      `CHK("area_dram", TBL[8*c+4 +: 4], area_dram)
      `CHK("pin_func", pf(TBL[8*c +: 4], {2'h0, {2{c[0]}}}), pin_func)
      `CHK("dram_control_b_eff", c != 0, dram_control_b_effective)
      `CHK("burst_mode", 1'b0, burst_mode)
    end
    for (int b = 0; b < 2; b++)
    begin
      for (int s = 0; s < 8; s++) nbr(s[1:0], s[2], b == 1, b == 0 && s == 1);
      axi_wr(`DAC_OFF, 8'h00, `RESP_OKAY);
    end
    for (int h = 0; h < 2; h++)
    begin
      axi_wr(`DAC_OFF, {3'h1, 2'h1, h[0], 2'h0}, `RESP_OKAY);
      @(negedge clk);
      `CHK("burst_mode", 1'b1, burst_mode)
      @(posedge clk);
      burst_go <= 1'b1;
      cyc(1);
      burst_go <= 1'b0;
      cyc(8);
      @(negedge clk);
      `CHK("ras_hold", h[0], ras_hold)
      axi_wr(`DAC_OFF, 8'h00, `RESP_OKAY);
    end
    for (int m = 0; m < 2; m++)
    begin
      v = m ? 8'h02 : 8'h23;
      axi_wr(`DAC_OFF, v, `RESP_OKAY);
      ref_lvl <= 1'(rnd());
      cyc(3);
      sw_standby <= 1'b1;
      cyc(3);
      @(negedge clk);
      `CHK("refresh_pin_oe", m == 0, refresh_pin_oe)
      if (m == 0) `CHK("refresh_pin_o", ref_lvl, refresh_pin_o)
      `CHK("self_refresh", m == 0, self_refresh)
      axi_rd(`DAC_OFF, {24'h0, v | `DAC_RO_MASK}, `RESP_OKAY);
      axi_rd(`STAT_OFF, m ? 32'h00000000 : 32'h00000091, `RESP_OKAY);
      sw_standby <= 1'b0;
      cyc(3);
      @(negedge clk);
      `CHK("self_refresh", 1'b0, self_refresh)
    end
    axi_wr(`CSO_OFF, 8'hf0, `RESP_OKAY);
    hw_standby <= 1'b1;
    cyc(2);
    hw_standby <= 1'b0;
    axi_rd(`CSO_OFF, 32'h0000000f, `RESP_OKAY);
    axi_rd(`DAC_OFF, 32'h00000010, `RESP_OKAY);
    cyc(4);
    print_verdict();
  end
endmodule // chip_select_dram_area_control_tb
`default_nettype wire
